//--- hdl/e3_rx_map.svh
`ifndef E3_RX_MAP_SVH
`define E3_RX_MAP_SVH

// Register indices, byte address is four times the index
`define IDX_DEFECT_STATE 6'h11
`define IDX_ENABLE_ONE   6'h12
`define IDX_ENABLE_TWO   6'h13
`define IDX_FLAGS_ONE    6'h14
`define IDX_FLAGS_TWO    6'h15
`define IDX_TRACE_FIRST  6'h1C
`define IDX_TRACE_LAST   6'h2B

// Writable and readable bit masks
`define ENABLE_ONE_MASK  8'h1F
`define ENABLE_TWO_MASK  8'h5F
`define REG_RESET        8'h00

// Flag register one bit positions
`define F1_ALARM 0
`define F1_LOS   1
`define F1_LOF   2
`define F1_OOF   3
`define F1_FRAMING_ALIGNMENT_CHANGE  4

// Flag register two bit positions
`define F2_PLD_MIS  0
`define F2_FBYTE    1
`define F2_PARITY   2
`define F2_FAR_FAIL 3
`define F2_FAR_END_BLOCK_ERROR     4
`define F2_TRACE    6

// Defect state register bit positions
`define DS_FAR_FAIL 0
`define DS_ALGO     7

// Alarm signal zero thresholds
`define ALARM_DECLARE_MAX 5'h07
`define ALARM_CLEAR_MIN   4'h8

// Trace message length in bytes
`define TRACE_LEN 16

`endif

//--- hdl/e3_rx_pkg.sv
package e3_rx_pkg;

  // Receive stream from the framer, same clock
  typedef struct packed {
    logic       frame_end;
    logic       bit_valid;
    logic       bit_value;
    logic       far_fail_bit;
    logic       trace_valid;
    logic [3:0] trace_index;
    logic [7:0] trace_byte;
    logic       trace_done;
  } rx_stream_type;

  // States and events of neighbouring framer logic
  typedef struct packed {
    logic loss_of_frame_state;
    logic out_of_frame_state;
    logic loss_of_signal_state;
    logic payload_unstable_state;
    logic trace_mark_state;
    logic framing_alignment_change;
    logic out_of_frame;
    logic loss_of_frame;
    logic loss_of_signal;
    logic far_end_block_error;
    logic parity_byte_error;
    logic framing_byte_error;
    logic payload_mismatch;
  } framer_status_type;

endpackage

//--- hdl/defect_flag.sv
`timescale 1ns/100ps
`default_nettype none

module defect_flag
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic declare,
  input  wire logic clear,
  output logic      state,
  output logic      change
);

  logic next_state;
  logic next_change;

  // Change pulse when a declare or clear alters the state
  always_comb
  begin
    next_state = state;
    if (declare)
    begin
      next_state = 1'b1;
    end
    else if (clear)
    begin
      next_state = 1'b0;
    end
    next_change = next_state != state;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state  <= 1'b0;
      change <= 1'b0;
    end
    else
    begin
      state  <= next_state;
      change <= next_change;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_flag_declare: assert property (
    declare && !state |=> state && change)
    else $error("defect not declared");
  a_flag_clear: assert property (
    clear && !declare |=> !state)
    else $error("defect not cleared");
  a_flag_follow: assert property (
    declare || clear |=> state == $past(declare))
    else $error("defect state wrong");

endmodule

`default_nettype wire

//--- hdl/e3_rx_alarm_trace_interrupts.sv
// The APB slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "e3_rx_map.svh"

module e3_rx_alarm_trace_interrupts
(
  input  wire logic                         ref_clk,
  input  wire logic                         rst_n,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [7:0]                   paddr,
  input  wire logic [31:0]                  pwdata,
  output logic [31:0]                       prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire e3_rx_pkg::rx_stream_type     rx,
  input  wire e3_rx_pkg::framer_status_type stat,
  output logic                              frame_loss_algorithm_select,
  output logic                              auto_far_failure_on_alarm,
  output logic                              irq_n
);

  logic [5:0]       idx;
  logic             setup;
  logic             access;
  logic [3:0]       zero_cnt;
  logic [3:0]       prev_zeros;
  logic [3:0]       cur_zeros;
  logic [4:0]       pair_sum;
  logic [3:0]       next_zero_cnt;
  logic [3:0]       next_prev_zeros;
  logic             alarm_declare, alarm_clear;
  logic             alarm_state, alarm_change;
  logic             far_state, far_change;
  logic [15:0][7:0] shadow;
  logic [15:0][7:0] msg;
  logic [15:0][7:0] next_shadow;
  logic [15:0][7:0] next_msg;
  logic             trace_change;
  logic             next_trace_change;
  logic [7:0]       en1, en2;
  logic [7:0]       flags1, flags2;
  logic [7:0]       next_en1, next_en2;
  logic [7:0]       next_flags1, next_flags2;
  logic             next_algo;
  logic [7:0]       set1, set2;
  logic [7:0]       clr1, clr2;
  logic [7:0]       mask1, mask2;
  logic [7:0]       next_mask1, next_mask2;
  logic [7:0]       rd_val;
  logic [7:0]       state_val;
  logic             rd_hit;
  logic             err;
  logic [31:0]      next_prdata;
  logic             next_err;
  logic             next_irq_n;
  logic [3:0]       trace_sel;

  assign idx    = paddr[7:2];
  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign pready = access;
  assign pslverr = access && err;

  // Zeros per frame, saturating at the clear threshold
  always_comb
  begin
    cur_zeros = zero_cnt;
    if (rx.bit_valid && !rx.bit_value && zero_cnt < `ALARM_CLEAR_MIN)
    begin
      cur_zeros = zero_cnt + 4'h1;
    end
    pair_sum        = {1'b0, prev_zeros} + {1'b0, cur_zeros};
    next_zero_cnt   = cur_zeros;
    next_prev_zeros = prev_zeros;
    alarm_declare   = 1'b0;
    alarm_clear     = 1'b0;
    if (rx.frame_end)
    begin
      next_zero_cnt   = 4'h0;
      next_prev_zeros = cur_zeros;
      alarm_declare   = pair_sum <= `ALARM_DECLARE_MAX;
      alarm_clear     = prev_zeros >= `ALARM_CLEAR_MIN &&
                        cur_zeros >= `ALARM_CLEAR_MIN;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      zero_cnt   <= 4'h0;
      prev_zeros <= `ALARM_CLEAR_MIN;
    end
    else
    begin
      zero_cnt   <= next_zero_cnt;
      prev_zeros <= next_prev_zeros;
    end
  end

  defect_flag alarm_flag
  (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .declare (alarm_declare),
    .clear   (alarm_clear),
    .state   (alarm_state),
    .change  (alarm_change)
  );

  // Far-end failure follows the failure bit of each frame
  defect_flag far_flag
  (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .declare (rx.frame_end && rx.far_fail_bit),
    .clear   (rx.frame_end && !rx.far_fail_bit),
    .state   (far_state),
    .change  (far_change)
  );

  // Trace assembly and change detection
  always_comb
  begin
    next_shadow       = shadow;
    next_msg          = msg;
    next_trace_change = 1'b0;
    if (rx.trace_valid)
    begin
      next_shadow[rx.trace_index] = rx.trace_byte;
    end
    if (rx.trace_done && shadow != msg)
    begin
      next_msg          = shadow;
      next_trace_change = 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      shadow       <= '0;
      msg          <= '0;
      trace_change <= 1'b0;
    end
    else
    begin
      shadow       <= next_shadow;
      msg          <= next_msg;
      trace_change <= next_trace_change;
    end
  end

  // Read decode
  always_comb
  begin
    state_val = {frame_loss_algorithm_select, stat.loss_of_frame_state,
                 stat.out_of_frame_state, stat.loss_of_signal_state,
                 alarm_state, stat.payload_unstable_state,
                 stat.trace_mark_state, far_state};
    trace_sel = 4'(idx - `IDX_TRACE_FIRST);
    rd_val    = 8'h00;
    rd_hit    = 1'b1;
    if (idx == `IDX_DEFECT_STATE)
    begin
      rd_val = state_val;
    end
    else if (idx == `IDX_ENABLE_ONE)
    begin
      rd_val = en1;
    end
    else if (idx == `IDX_ENABLE_TWO)
    begin
      rd_val = en2;
    end
    else if (idx == `IDX_FLAGS_ONE)
    begin
      rd_val = flags1;
    end
    else if (idx == `IDX_FLAGS_TWO)
    begin
      rd_val = flags2;
    end
    else if (idx >= `IDX_TRACE_FIRST && idx <= `IDX_TRACE_LAST)
    begin
      rd_val = msg[trace_sel];
    end
    else
    begin
      rd_hit = 1'b0;
    end
  end

  // Register file and flag updates
  always_comb
  begin
    next_prdata = prdata;
    next_err    = err;
    next_mask1  = mask1;
    next_mask2  = mask2;
    if (setup)
    begin
      next_prdata = {24'h000000, rd_val};
      next_err    = !rd_hit;
      next_mask1  = (!pwrite && idx == `IDX_FLAGS_ONE) ? flags1 : 8'h00;
      next_mask2  = (!pwrite && idx == `IDX_FLAGS_TWO) ? flags2 : 8'h00;
    end
    next_en1  = en1;
    next_en2  = en2;
    next_algo = frame_loss_algorithm_select;
    if (access && pwrite && !err)
    begin
      if (idx == `IDX_ENABLE_ONE)
      begin
        next_en1 = pwdata[7:0] & `ENABLE_ONE_MASK;
      end
      else if (idx == `IDX_ENABLE_TWO)
      begin
        next_en2 = pwdata[7:0] & `ENABLE_TWO_MASK;
      end
      else if (idx == `IDX_DEFECT_STATE)
      begin
        next_algo = pwdata[`DS_ALGO];
      end
    end
    set1 = {3'b000, stat.framing_alignment_change, stat.out_of_frame,
            stat.loss_of_frame, stat.loss_of_signal, alarm_change} & en1;
    set2 = {1'b0, trace_change, 1'b0, stat.far_end_block_error, far_change,
            stat.parity_byte_error, stat.framing_byte_error,
            stat.payload_mismatch} & en2;
    clr1 = (access && !pwrite) ? mask1 : 8'h00;
    clr2 = (access && !pwrite) ? mask2 : 8'h00;
    next_flags1 = (flags1 & ~clr1) | set1;
    next_flags2 = (flags2 & ~clr2) | set2;
    next_irq_n  = ~|((flags1 & en1) | (flags2 & en2));
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      prdata                      <= 32'h00000000;
      err                         <= 1'b0;
      mask1                       <= 8'h00;
      mask2                       <= 8'h00;
      en1                         <= `REG_RESET;
      en2                         <= `REG_RESET;
      frame_loss_algorithm_select <= 1'b0;
      flags1                      <= `REG_RESET;
      flags2                      <= `REG_RESET;
      irq_n                       <= 1'b1;
      auto_far_failure_on_alarm   <= 1'b0;
    end
    else
    begin
      prdata                      <= next_prdata;
      err                         <= next_err;
      mask1                       <= next_mask1;
      mask2                       <= next_mask2;
      en1                         <= next_en1;
      en2                         <= next_en2;
      frame_loss_algorithm_select <= next_algo;
      flags1                      <= next_flags1;
      flags2                      <= next_flags2;
      irq_n                       <= next_irq_n;
      auto_far_failure_on_alarm   <= alarm_state;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_read_one;
    setup && !pwrite && idx == `IDX_FLAGS_ONE ##1 access;
  endsequence
  sequence s_read_two;
    setup && !pwrite && idx == `IDX_FLAGS_TWO ##1 access;
  endsequence

  a_alarm_flag: assert property (
    alarm_change && en1[`F1_ALARM] |=> flags1[`F1_ALARM])
    else $error("alarm flag not set");
  a_flags_one_read: assert property (
    s_read_one ##0 set1 == 8'h00 |=> (flags1 & $past(mask1)) == 8'h00)
    else $error("flag one not cleared by read");
  a_flags_two_read: assert property (
    s_read_two ##0 set2 == 8'h00 |=> (flags2 & $past(mask2)) == 8'h00)
    else $error("flag two not cleared by read");
  a_reserved_zero: assert property (
    access && !pwrite && idx == `IDX_FLAGS_TWO |->
    prdata[7] == 1'b0 && prdata[5] == 1'b0 && prdata[31:8] == 24'h000000)
    else $error("reserved bits not zero");
  a_far_tx: assert property (
    1'b1 |=> auto_far_failure_on_alarm == $past(alarm_state))
    else $error("far failure not following alarm");
  a_trace_flag: assert property (
    rx.trace_done && shadow != msg && en2[`F2_TRACE] |=>
    msg == $past(shadow) ##1 flags2[`F2_TRACE] ##1 !irq_n)
    else $error("trace change not flagged");
  a_far_flag: assert property (
    far_change && en2[`F2_FAR_FAIL] |=> flags2[`F2_FAR_FAIL] ##1 !irq_n)
    else $error("far failure flag not set");
  a_irq_level: assert property (
    ((flags1 & en1) | (flags2 & en2)) == 8'h00 ##1
    ((flags1 & en1) | (flags2 & en2)) == 8'h00 |-> irq_n)
    else $error("request low without flags");

endmodule

`default_nettype wire

//--- verif/frame_source.sv
`timescale 1ns/100ps
`default_nettype none

module frame_source
(
  input  wire logic                   ref_clk,
  output var e3_rx_pkg::rx_stream_type rx
);
  initial rx = '0;

  // One frame of eight bits, zeros first
  task automatic send_frame(input int zeros, input logic far);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge ref_clk);
      rx.bit_valid <= 1'b1;
      rx.bit_value <= (i >= zeros);
    end
    @(posedge ref_clk);
    rx.bit_valid    <= 1'b0;
    rx.frame_end    <= 1'b1;
    rx.far_fail_bit <= far;
    @(posedge ref_clk);
    rx.frame_end    <= 1'b0;
    rx.far_fail_bit <= ~far;
    rx.bit_value    <= ~rx.bit_value;
  endtask

  // Sixteen byte message, then done pulse
  task automatic send_trace(input logic [7:0] base);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge ref_clk);
      rx.trace_valid <= 1'b1;
      rx.trace_index <= i[3:0];
      rx.trace_byte  <= base + i[7:0];
    end
    @(posedge ref_clk);
    rx.trace_valid <= 1'b0;
    rx.trace_done  <= 1'b1;
    rx.trace_byte  <= ~rx.trace_byte;
    @(posedge ref_clk);
    rx.trace_done <= 1'b0;
  endtask
endmodule

`default_nettype wire

//--- verif/tb_e3_rx_alarm_trace_interrupts.sv
`timescale 1ns/100ps
`default_nettype none

module tb_e3_rx_alarm_trace_interrupts;
  logic                         ref_clk = 1'b0;
  logic                         rst_n   = 1'b0;
  logic                         psel    = 1'b0;
  logic                         penable = 1'b0;
  logic                         pwrite  = 1'b0;
  logic [7:0]                   paddr   = 8'h00;
  logic [31:0]                  pwdata  = 32'h00000000;
  logic [31:0]                  prdata;
  logic                         pready;
  logic                         pslverr;
  logic                         algo_sel;
  logic                         auto_far;
  logic                         irq_n;
  logic                         err_seen;
  logic [31:0]                  rd;
  e3_rx_pkg::rx_stream_type     rx;
  e3_rx_pkg::framer_status_type stat = '0;
  int                           fails = 0;
  int                           tests_run = 0;
  int                           k;

  always #5 ref_clk = ~ref_clk;

  e3_rx_alarm_trace_interrupts e3_rx_alarm_trace_interrupts_inst
  (
    .ref_clk                     (ref_clk),
    .rst_n                       (rst_n),
    .psel                        (psel),
    .penable                     (penable),
    .pwrite                      (pwrite),
    .paddr                       (paddr),
    .pwdata                      (pwdata),
    .prdata                      (prdata),
    .pready                      (pready),
    .pslverr                     (pslverr),
    .rx                          (rx),
    .stat                        (stat),
    .frame_loss_algorithm_select (algo_sel),
    .auto_far_failure_on_alarm   (auto_far),
    .irq_n                       (irq_n)
  );

  frame_source frame_source_inst
  (
    .ref_clk (ref_clk),
    .rx      (rx)
  );

  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] d);
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    rd = prdata;
    err_seen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check(rd, {24'h000000, exp});
  endtask

  task automatic bit_chk(input logic got, input logic exp);
    check({31'h00000000, got}, {31'h00000000, exp});
  endtask

  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge ref_clk);
    #1;
    bit_chk(irq_n, exp);
  endtask

  task automatic frame(input int z, input logic f);
    frame_source_inst.send_frame(z, f);
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic trace(input logic [7:0] base);
    frame_source_inst.send_trace(base);
    repeat (4) @(posedge ref_clk);
  endtask

  initial
  begin
    #100000;
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    tally_and_finish;
  end

  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_chk(6'h11, 8'h00);
    rd_chk(6'h13, 8'h00);
    rd_chk(6'h14, 8'h00);
    rd_chk(6'h15, 8'h00);
    bit_chk(irq_n, 1'b1);
    apb(1'b0, 6'h10, 8'h00);
    bit_chk(err_seen, 1'b1);
    check(rd, 32'h00000000);
    apb(1'b1, 6'h12, 8'hFF);
    rd_chk(6'h12, 8'h1F);
    apb(1'b1, 6'h13, 8'hFF);
    rd_chk(6'h13, 8'h5F);
    apb(1'b1, 6'h11, 8'hFF);
    rd_chk(6'h11, 8'h80);
    bit_chk(algo_sel, 1'b1);
    apb(1'b1, 6'h11, 8'h00);
    apb(1'b1, 6'h14, 8'hFF);
    rd_chk(6'h14, 8'h00);
    apb(1'b1, 6'h13, 8'h48);
    $display("Test registers done");
    frame(8, 1'b1);
    bit_chk(irq_n, 1'b0);
    rd_chk(6'h11, 8'h01);
    rd_chk(6'h15, 8'h08);
    irq_chk(1'b1);
    rd_chk(6'h15, 8'h00);
    frame(8, 1'b0);
    rd_chk(6'h11, 8'h00);
    rd_chk(6'h15, 8'h08);
    apb(1'b1, 6'h13, 8'h00);
    frame(8, 1'b1);
    rd_chk(6'h15, 8'h00);
    bit_chk(irq_n, 1'b1);
    apb(1'b1, 6'h13, 8'h48);
    frame(8, 1'b0);
    rd_chk(6'h15, 8'h08);
    $display("Test far-end failure done");
    frame(4, 1'b0);
    frame(4, 1'b0);
    rd_chk(6'h11, 8'h00);
    frame(3, 1'b0);
    rd_chk(6'h11, 8'h08);
    bit_chk(auto_far, 1'b1);
    rd_chk(6'h14, 8'h01);
    frame(8, 1'b0);
    rd_chk(6'h11, 8'h08);
    frame(8, 1'b1);
    rd_chk(6'h11, 8'h01);
    bit_chk(auto_far, 1'b0);
    rd_chk(6'h14, 8'h01);
    irq_chk(1'b0);
    rd_chk(6'h15, 8'h08);
    irq_chk(1'b1);
    $display("Test alarm done");
    trace(8'hA0);
    bit_chk(irq_n, 1'b0);
    rd_chk(6'h15, 8'h40);
    for (k = 0; k < 16; k++)
      rd_chk(6'h1C + k[5:0], 8'hA0 + k[7:0]);
    rd_chk(6'h15, 8'h00);
    trace(8'hA0);
    rd_chk(6'h15, 8'h00);
    apb(1'b1, 6'h13, 8'h08);
    trace(8'h30);
    rd_chk(6'h15, 8'h00);
    bit_chk(irq_n, 1'b1);
    $display("Test trace done");
    apb(1'b1, 6'h13, 8'h5F);
    stat <= 13'h1FFF;
    @(posedge ref_clk);
    stat <= 13'h1F00;
    irq_chk(1'b0);
    rd_chk(6'h11, 8'h77);
    rd_chk(6'h14, 8'h1E);
    rd_chk(6'h15, 8'h17);
    irq_chk(1'b1);
    stat <= '0;
    $display("Test framer status done");
    tally_and_finish;
  end
endmodule

`default_nettype wire
